// ==== motion_sequence_command_control_bench.sv ====
// Self-checking bench for the motion and sequence command controller
`timescale 1ns/100ps
module motion_sequence_command_control_bench;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic sync_pin = 0, gain = 0, func = 0, buf_empty = 1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, res = 32'h0000_0000;
  logic awr, wrdy, bv, arr, rv, mfwd, mbwd, find, bwi, clr, start, abrt, tsync, atrig, pop;
  logic idx, sdone;
  logic [1:0] bresp, rresp, offset_adjust_cmd, rd_r, wr_r;
  logic [2:0] tsrc;
  logic [31:0] rdata, rd_d;
  int n_fail = 0, checks = 0, n_start = 0, n_abort = 0, n_trig = 0, n_pop = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    n_start += start;
    n_abort += abrt;
    n_trig += atrig;
    n_pop += pop;
  end
  mscc_top #(.ADJ_CYCLES(20)) mscc_top_i (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .ENC_INDEX(idx), .EXT_SYNC(sync_pin), .GAIN_BTN(gain), .FUNC_BTN(func),
    .SEQ_DONE(sdone), .BUF_EMPTY(buf_empty), .RESULT_DATA(res), .MOTOR_FWD(mfwd),
    .MOTOR_BWD(mbwd), .FORWARD_IND(find), .BACKWARD_IND(bwi), .CNT_CLR(clr),
    .SEQ_START(start), .SEQ_ABORT(abrt), .TRIG_SRC(tsrc), .TRIG_SYNC(tsync),
    .ADJ_ACTIVE(offset_adjust_cmd), .ADJ_TRIG(atrig), .RESULT_POP(pop));
  mscc_plant mscc_plant_i (.clk(clk), .nrst(nrst), .motor_fwd(mfwd), .motor_bwd(mbwd),
    .seq_start(start), .seq_abort(abrt), .enc_index(idx), .seq_done(sdone));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    $display("ERROR wait expected done seen none");
    tally_and_finish();
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Each transfer starts one edge late so no strobe is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awr)
        awv <= 0;
      if (wrdy)
        wv <= 0;
      if (bv)
      begin
        wr_r = bresp;
        bready <= 0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rready <= 1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arr)
        arv <= 0;
      if (rv)
      begin
        rd_d = rdata;
        rd_r = rresp;
        rready <= 0;
        return;
      end
    end
    hang();
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [7:0] c);
    wr(8'h00, {16'h0000, c, a, op});
    #1;
  endtask
  function automatic logic [31:0] mk(input logic [7:0] c, input logic l);
    mk = {22'h00_0000, 1'b1, l, c};
  endfunction
  function automatic logic [31:0] motor_cmd();
    motor_cmd = {28'h000_0000, mfwd, mbwd, find, bwi};
  endfunction
  initial
  begin
    int k;
    logic [7:0] c1, c2;
    void'($urandom(32'hd13f));
    repeat (10) @(posedge clk);
    nrst <= 1;
    rd(8'h10); cmp("fetch", mk(8'h1A, 1), rd_d);
    rd(8'h3C); cmp("rresp", 32'(2'h2), 32'(rd_r));
    rd(8'h04); cmp("stat1", 32'h0000_0000, rd_d);
    $display("test reset done");
    cmd(4'h4, 4'h1, 0); cmp("motor", 4'hA, motor_cmd());
    cmd(4'h4, 4'h2, 0); cmp("motor", 4'h5, motor_cmd());
    cmd(4'h4, 4'h3, 0); cmp("motor", 4'h0, motor_cmd());
    $display("test motor done");
    cmd(4'h3, 4'h0, 0); cmp("motor", 4'h0, motor_cmd());
    cmd(4'h3, 4'h1, 0); cmp("motor", 4'hA, motor_cmd());
    for (k = 0; k < 100 && clr !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (k == 100)
      hang();
    cmp("clr_motor", 1, mfwd);
    @(posedge clk);
    #1;
    cmp("stop_motor", 0, mfwd);
    rd(8'h04); cmp("homed", 1, rd_d[0]);
    wr(8'h04, 32'h0000_0011);
    $display("test homing done");
    cmd(4'h4, 4'h1, 0);
    cmd(4'h7, 4'h5, 0); cmp("motor", 4'h0, motor_cmd());
    cmp("src", 3'h5, tsrc);
    cmd(4'h1, 4'h2, 0); cmp("adj", 2'b10, offset_adjust_cmd);
    k = n_trig;
    repeat (90) @(posedge clk);
    cmp("trig", k + 4, n_trig);
    rd(8'h08); cmp("st3", 3'h0, rd_d[7:5]);
    cmd(4'h2, 4'h1, 0); cmp("adj", 2'b10, offset_adjust_cmd);
    cmd(4'h2, 4'h0, 0); cmp("adj", 2'b00, offset_adjust_cmd);
    rd(8'h08); cmp("st3", 3'h5, rd_d[7:5]);
    gain <= 1;
    func <= 1;
    repeat (8) @(posedge clk);
    gain <= 0;
    func <= 0;
    repeat (2) @(posedge clk);
    #1;
    cmp("adj", 2'b10, offset_adjust_cmd);
    cmd(4'h2, 4'h2, 0);
    $display("test adjust done");
    cmd(4'hB, 4'h2, 0);
    cmd(4'h4, 4'h4, 0);
    k = n_start;
    cmd(4'h5, 4'h0, 0); cmp("motor", 4'h5, motor_cmd());
    cmp("start", k + 1, n_start);
    cmd(4'h5, 4'h0, 0);
    rd(8'h04); cmp("synerr", 1, rd_d[4]);
    repeat (60) @(posedge clk);
    #1;
    cmp("motor", 4'h0, motor_cmd());
    wr(8'h04, 32'h0000_0010);
    cmd(4'h4, 4'h4, 0);
    cmd(4'h4, 4'h3, 0);
    cmd(4'h5, 4'h0, 0); cmp("motor", 4'h0, motor_cmd());
    repeat (60) @(posedge clk);
    $display("test auto done");
    cmd(4'h7, 4'h9, 0); cmp("sync", 1, tsync);
    k = n_start;
    cmd(4'h5, 4'h0, 0);
    repeat (10) @(posedge clk);
    cmp("start", k, n_start);
    sync_pin <= 1;
    repeat (6) @(posedge clk);
    sync_pin <= 0;
    repeat (10) @(posedge clk);
    cmp("start", k + 1, n_start);
    repeat (60) @(posedge clk);
    cmd(4'h7, 4'h0, 0);
    cmd(4'h4, 4'h1, 0);
    cmd(4'h5, 4'h0, 0);
    k = n_abort;
    cmd(4'h6, 4'h0, 0); cmp("motor", 4'h0, motor_cmd());
    cmp("abort", k + 1, n_abort);
    $display("test run done");
    for (int i = 0; i < 3; i++)
    begin
      c1 = 8'(8'h21 + $urandom % 94);
      c2 = 8'(8'h21 + $urandom % 94);
      cmd(4'h9, 4'h0, c1);
      cmd(4'hA, 4'h0, c2);
      rd(8'h14); cmp("marklen", 2, rd_d);
      rd(8'h10); cmp("fetch", mk(c1, 0), rd_d);
      rd(8'h10); cmp("fetch", mk(c2, 1), rd_d);
      cmd(4'h8, 4'h0, 0);
      rd(8'h10); cmp("fetch", mk(8'h1A, 1), rd_d);
      buf_empty <= 0;
      res <= $urandom;
      rd(8'h10); cmp("fetch", res, rd_d);
      buf_empty <= 1;
    end
    wr(8'h3C, 32'h0000_0000); cmp("bresp", 32'(2'h2), 32'(wr_r));
    cmp("pop", 3, n_pop);
    $display("test marker done");
    tally_and_finish();
  end
endmodule

// ==== mscc_pkg.sv ====
// Constants for the motion and sequence command controller
// Contract
// RQ1 - Offset-adjust-on command puts the addressed channel into offset-adjust mode.
// RQ2 - Offset-adjust-off leaves the mode on given or active channel; otherwise ignored.
// RQ3 - In offset-adjust mode, trigger endlessly every 300 ms and display each value.
// RQ4 - Gain and function buttons pressed together also enter offset-adjust mode.
// RQ5 - Status word three bits 7, 6, 5 read zero during offset-adjust mode.
// RQ6 - Homing with direction drives motor until encoder index or sync pulse.
// RQ7 - Homing end: clear trigger counter, then stop motor, then set status one bit 0.
// RQ8 - Homing command without direction leaves the motor still.
// RQ9 - Motor plus starts forward, motor minus starts backward.
// RQ10 - Motor-stop stops the motor and disarms automatic-motor mode.
// RQ11 - Armed automatic mode starts the motor on run, in sequence direction.
// RQ12 - Automatic mode stops the motor when the measurement sequence finishes.
// RQ13 - Run starts the sequence at once, or waits for sync if synchronized.
// RQ14 - Run during a sequence in progress flags a syntax error.
// RQ15 - Abort halts the sequence, stops the motor, ends external-trigger measurement.
// RQ16 - End-marker command stores a marker string from decimal character codes.
// RQ17 - Result fetch with empty buffer returns the stored end-marker string.
// RQ18 - Marker is the single character 26 at power-on or with empty list.
// RQ19 - Forward indicator lit while running forward, backward while running backward.
// RQ20 - Trigger source select cancels sequence, stops motor, disarms automatic mode.
// RQ21 - Host homes the encoder before runs that rely on a defined zero.
package mscc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAT1 = 8'h04;
  localparam logic [7:0] OFS_STAT3 = 8'h08;
  localparam logic [7:0] OFS_MOTOR = 8'h0C;
  localparam logic [7:0] OFS_FETCH = 8'h10;
  localparam logic [7:0] OFS_MARKLEN = 8'h14;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ARG_LSB = 4;
  localparam int CMD_CHR_LSB = 8;
  // Opcodes
  localparam logic [3:0] OP_ADJ_ON = 4'h1;
  localparam logic [3:0] OP_ADJ_OFF = 4'h2;
  localparam logic [3:0] OP_HOME = 4'h3;
  localparam logic [3:0] OP_MOTOR = 4'h4;
  localparam logic [3:0] OP_RUN = 4'h5;
  localparam logic [3:0] OP_ABORT = 4'h6;
  localparam logic [3:0] OP_TRS = 4'h7;
  localparam logic [3:0] OP_EOD_DFLT = 4'h8;
  localparam logic [3:0] OP_EOD_NEW = 4'h9;
  localparam logic [3:0] OP_EOD_ADD = 4'hA;
  localparam logic [3:0] OP_SEQ_DEF = 4'hB;
  // Direction and motor arguments
  localparam logic [3:0] ARG_NONE = 4'h0;
  localparam logic [3:0] ARG_PLUS = 4'h1;
  localparam logic [3:0] ARG_MINUS = 4'h2;
  localparam logic [3:0] ARG_STOP = 4'h3;
  localparam logic [3:0] ARG_AUTO = 4'h4;
  // Status one bits
  localparam int ST1_HOMED = 0;
  localparam int ST1_BUSY = 1;
  localparam int ST1_SYNERR = 4;
  // Reset values and bus response codes
  localparam logic [7:0] MARK_DFLT = 8'h1A;
  localparam logic [2:0] TRS_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam longint CLK_HZ = 40_000_000;
  localparam longint ADJ_PERIOD_MS = 300;
  localparam int ADJ_CYCLES = int'((ADJ_PERIOD_MS * CLK_HZ) / 1000);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEEK = 2'b01, H_CLEAR = 2'b10,
                            H_STOP = 2'b11} mscc_home_t;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_WAIT = 2'b01, S_RUN = 2'b10} mscc_seq_t;
endpackage

// ==== mscc_plant.sv ====
// Motor, encoder and sequencer stand-in for the controller bench
`timescale 1ns/100ps
module mscc_plant (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // From controller
  input wire logic motor_fwd,
  input wire logic motor_bwd,
  input wire logic seq_start,
  input wire logic seq_abort,
  // To controller
  output logic enc_index,
  output logic seq_done
);
  int mot_q;
  int seq_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mot_q <= 0;
      seq_q <= 0;
    end
    else
    begin
      mot_q <= (motor_fwd || motor_bwd) ? mot_q + 1 : 0;
      if (seq_start)
        seq_q <= 40;
      else if (seq_abort)
        seq_q <= 0;
      else if (seq_q != 0)
        seq_q <= seq_q - 1;
    end
  end
  // Index held six cycles so the pin filter cannot drop it
  assign enc_index = (mot_q >= 30) && (mot_q < 36);
  assign seq_done = (seq_q == 1);
endmodule

// ==== mscc_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module mscc_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins and clean levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end
        else
        begin
          s1_q <= pin[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Only an agreed level passes, so one-cycle glitches are dropped
          if (s2_q == s3_q)
            lvl_q <= s3_q;
        end
      end
      assign lvl[g] = lvl_q;
    end
  endgenerate
endmodule

// ==== mscc_top.sv ====
// Motion and sequence command controller with AXI4-Lite registers
`timescale 1ns/100ps
module mscc_top #(
  parameter int ADJ_CYCLES = mscc_pkg::ADJ_CYCLES,
  parameter int MARK_DEPTH = 16,
  parameter int NCHAN = 2
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // AXI4-Lite write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Asynchronous pins
  input wire logic ENC_INDEX,
  input wire logic EXT_SYNC,
  input wire logic GAIN_BTN,
  input wire logic FUNC_BTN,
  // Sequencer and result buffer, same clock
  input wire logic SEQ_DONE,
  input wire logic BUF_EMPTY,
  input wire logic [31:0] RESULT_DATA,
  // Motor and panel
  output logic MOTOR_FWD,
  output logic MOTOR_BWD,
  output logic FORWARD_IND,
  output logic BACKWARD_IND,
  // Trigger and sequence control
  output logic CNT_CLR,
  output logic SEQ_START,
  output logic SEQ_ABORT,
  output logic [2:0] TRIG_SRC,
  output logic TRIG_SYNC,
  output logic [NCHAN-1:0] ADJ_ACTIVE,
  output logic ADJ_TRIG,
  output logic RESULT_POP
);
  localparam int ADJ_W = $clog2(ADJ_CYCLES + 1);
  localparam int PW = $clog2(MARK_DEPTH);
  localparam logic [PW:0] LEN_MAX = (PW + 1)'(MARK_DEPTH);

  // Pin synchronisers
  logic [3:0] pin_lvl;
  logic idx_prev_q;
  logic syn_prev_q;
  logic btn_prev_q;
  mscc_sync #(.W(4)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .pin({FUNC_BTN, GAIN_BTN, EXT_SYNC, ENC_INDEX}),
    .lvl(pin_lvl)
  );
  wire idx_evt = pin_lvl[0] & ~idx_prev_q;
  wire syn_evt = pin_lvl[1] & ~syn_prev_q;
  wire both_btn = pin_lvl[2] & pin_lvl[3];
  wire btn_evt = both_btn & ~btn_prev_q;

  // AXI write channel
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic awready_q;
  logic wready_q;
  wire aw_take = S_AXI_AWVALID & ~aw_have_q & ~bvalid_q;
  wire w_take = S_AXI_WVALID & ~w_have_q & ~bvalid_q;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  // Readies come from flops; their next value mirrors the next holding state
  wire bvalid_d = wr_go | (bvalid_q & ~S_AXI_BREADY);
  wire awready_d = ~bvalid_d & ~aw_have_q & ~aw_take;
  wire wready_d = ~bvalid_d & ~w_have_q & ~w_take;
  wire wr_map = (aw_addr_q == mscc_pkg::OFS_CMD) || (aw_addr_q == mscc_pkg::OFS_STAT1);
  wire cmd_go = wr_go & (aw_addr_q == mscc_pkg::OFS_CMD) & (&w_strb_q[1:0]);
  wire st1_wr = wr_go & (aw_addr_q == mscc_pkg::OFS_STAT1) & w_strb_q[0];
  wire [3:0] op = w_data_q[mscc_pkg::CMD_OP_LSB +: 4];
  wire [3:0] arg = w_data_q[mscc_pkg::CMD_ARG_LSB +: 4];
  wire [7:0] chr = w_data_q[mscc_pkg::CMD_CHR_LSB +: 8];

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= mscc_pkg::RESP_OKAY;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end
    else
    begin
      if (aw_take)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (w_take)
      begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? mscc_pkg::RESP_OKAY : mscc_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && S_AXI_BREADY)
        bvalid_q <= 1'b0;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // Command strobes
  wire c_adj_on = cmd_go && op == mscc_pkg::OP_ADJ_ON;
  wire c_adj_off = cmd_go && op == mscc_pkg::OP_ADJ_OFF;
  wire c_home = cmd_go && op == mscc_pkg::OP_HOME;
  wire c_mot = cmd_go && op == mscc_pkg::OP_MOTOR;
  wire c_run = cmd_go && op == mscc_pkg::OP_RUN;
  wire c_abort = cmd_go && op == mscc_pkg::OP_ABORT;
  wire c_trs = cmd_go && op == mscc_pkg::OP_TRS;
  wire c_seqdef = cmd_go && op == mscc_pkg::OP_SEQ_DEF;
  wire c_mot_fwd = c_mot && arg == mscc_pkg::ARG_PLUS;
  wire c_mot_bwd = c_mot && arg == mscc_pkg::ARG_MINUS;
  wire c_mot_stop = c_mot && arg == mscc_pkg::ARG_STOP;
  wire c_mot_auto = c_mot && arg == mscc_pkg::ARG_AUTO;
  wire c_home_dir = c_home && (arg == mscc_pkg::ARG_PLUS || arg == mscc_pkg::ARG_MINUS);

  // Offset adjust
  logic [NCHAN-1:0] adj_q;
  logic [NCHAN-1:0] act_q;
  logic [ADJ_W-1:0] adj_cnt_q;
  logic adj_trig_q;
  wire [NCHAN-1:0] off_mask = (arg[NCHAN-1:0] == '0) ? act_q : arg[NCHAN-1:0];
  // Clearing a channel not in the mode changes nothing, so no extra test is needed
  wire [NCHAN-1:0] adj_d = ((adj_q & ~({NCHAN{c_adj_off}} & off_mask))
                           | ({NCHAN{c_adj_on}} & arg[NCHAN-1:0])
                           | ({NCHAN{btn_evt}} & act_q)); // [RQ1] [RQ2] [RQ4]
  wire adj_any = |adj_q;
  wire adj_wrap = adj_cnt_q == ADJ_W'(ADJ_CYCLES - 1);
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      adj_q <= '0;
      act_q <= NCHAN'(1);
      adj_cnt_q <= '0;
      adj_trig_q <= 1'b0;
    end
    else
    begin
      adj_q <= adj_d;
      if (c_adj_on && arg[NCHAN-1:0] != '0)
        act_q <= arg[NCHAN-1:0];
      adj_cnt_q <= (!adj_any || adj_wrap) ? '0 : adj_cnt_q + 1'b1; // [RQ3]
      adj_trig_q <= adj_any & adj_wrap; // [RQ3]
    end
  end

  // Homing, sequence and motor
  mscc_pkg::mscc_home_t home_q;
  mscc_pkg::mscc_home_t home_d;
  mscc_pkg::mscc_seq_t seq_q;
  mscc_pkg::mscc_seq_t seq_d;
  logic fwd_q;
  logic bwd_q;
  logic auto_q;
  logic seq_def_q;
  logic seq_dir_q;
  logic [2:0] trs_q;
  logic trs_sync_q;
  logic homed_q;
  logic err_q;
  logic cnt_clr_q;
  logic seq_start_q;
  logic seq_abort_q;
  wire seq_fin = seq_q == mscc_pkg::S_RUN && SEQ_DONE;
  wire run_ok = c_run && seq_q == mscc_pkg::S_IDLE;
  wire run_bad = c_run && seq_q != mscc_pkg::S_IDLE; // [RQ14]
  wire home_hit = home_q == mscc_pkg::H_SEEK && (idx_evt || syn_evt); // [RQ6]
  wire mot_off = c_mot_stop || c_abort || c_trs || home_q == mscc_pkg::H_CLEAR
                 || (seq_fin && auto_q); // [RQ10] [RQ12] [RQ15] [RQ20] [RQ7]
  wire auto_go = run_ok && auto_q; // [RQ11]
  wire go_fwd = c_mot_fwd || (c_home_dir && arg == mscc_pkg::ARG_PLUS)
                || (auto_go && !seq_dir_q); // [RQ9] [RQ6]
  wire go_bwd = c_mot_bwd || (c_home_dir && arg == mscc_pkg::ARG_MINUS)
                || (auto_go && seq_dir_q);
  wire fwd_d = mot_off ? 1'b0 : (go_fwd ? 1'b1 : (go_bwd ? 1'b0 : fwd_q));
  wire bwd_d = mot_off ? 1'b0 : (go_bwd ? 1'b1 : (go_fwd ? 1'b0 : bwd_q));

  always_comb
  begin
    home_d = home_q;
    unique case (home_q)
      mscc_pkg::H_IDLE: if (c_home_dir) home_d = mscc_pkg::H_SEEK; // [RQ8]
      mscc_pkg::H_SEEK: if (home_hit) home_d = mscc_pkg::H_CLEAR;
      mscc_pkg::H_CLEAR: home_d = mscc_pkg::H_STOP;
      mscc_pkg::H_STOP: home_d = mscc_pkg::H_IDLE;
    endcase
    if (home_q == mscc_pkg::H_SEEK && (c_abort || c_mot_stop || c_trs))
      home_d = mscc_pkg::H_IDLE;
  end

  always_comb
  begin
    seq_d = seq_q;
    unique case (seq_q)
      mscc_pkg::S_IDLE: if (run_ok) seq_d = trs_sync_q ? mscc_pkg::S_WAIT : mscc_pkg::S_RUN;
      mscc_pkg::S_WAIT: if (syn_evt) seq_d = mscc_pkg::S_RUN; // [RQ13]
      mscc_pkg::S_RUN: if (SEQ_DONE) seq_d = mscc_pkg::S_IDLE;
      default: seq_d = mscc_pkg::S_IDLE;
    endcase
    if (c_abort || c_trs)
      seq_d = mscc_pkg::S_IDLE; // [RQ15] [RQ20]
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      home_q <= mscc_pkg::H_IDLE;
      seq_q <= mscc_pkg::S_IDLE;
      fwd_q <= 1'b0;
      bwd_q <= 1'b0;
      auto_q <= 1'b0;
      seq_def_q <= 1'b0;
      seq_dir_q <= 1'b0;
      trs_q <= mscc_pkg::TRS_RST;
      trs_sync_q <= 1'b0;
      homed_q <= 1'b0;
      err_q <= 1'b0;
      cnt_clr_q <= 1'b0;
      seq_start_q <= 1'b0;
      seq_abort_q <= 1'b0;
      idx_prev_q <= 1'b0;
      syn_prev_q <= 1'b0;
      btn_prev_q <= 1'b0;
    end
    else
    begin
      idx_prev_q <= pin_lvl[0];
      syn_prev_q <= pin_lvl[1];
      btn_prev_q <= both_btn;
      home_q <= home_d;
      seq_q <= seq_d;
      fwd_q <= fwd_d;
      bwd_q <= bwd_d;
      auto_q <= (auto_q | c_mot_auto) & ~c_mot_stop & ~c_trs; // [RQ10] [RQ20]
      seq_def_q <= (seq_def_q | c_seqdef) & ~c_trs; // [RQ20]
      if (c_seqdef)
        seq_dir_q <= arg == mscc_pkg::ARG_MINUS;
      if (c_trs)
      begin
        trs_q <= arg[2:0];
        trs_sync_q <= arg[3];
      end
      cnt_clr_q <= home_hit; // [RQ7]
      // Set wins over a same-cycle software clear
      homed_q <= (homed_q & ~(st1_wr & w_data_q[mscc_pkg::ST1_HOMED]))
                 | (home_q == mscc_pkg::H_STOP); // [RQ7]
      err_q <= (err_q & ~(st1_wr & w_data_q[mscc_pkg::ST1_SYNERR])) | run_bad; // [RQ14]
      seq_start_q <= (run_ok && !trs_sync_q)
                     || (seq_q == mscc_pkg::S_WAIT && syn_evt && !c_abort && !c_trs); // [RQ13]
      seq_abort_q <= c_abort; // [RQ15]
    end
  end

  // End-of-data marker store
  logic [7:0] mark_mem [MARK_DEPTH];
  logic [PW:0] mark_len_q;
  logic [PW-1:0] mark_ptr_q;
  logic mark_dflt_q;
  wire c_eod_new = cmd_go && op == mscc_pkg::OP_EOD_NEW;
  wire c_eod_add = cmd_go && op == mscc_pkg::OP_EOD_ADD && !mark_dflt_q && mark_len_q < LEN_MAX;
  wire [PW-1:0] mark_wa = c_eod_new ? '0 : mark_len_q[PW-1:0];
  always_ff @(posedge CLK)
  begin
    if (c_eod_new || c_eod_add)
      mark_mem[mark_wa] <= chr; // [RQ16]
  end

  // AXI read channel
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic pop_q;
  wire ar_take = S_AXI_ARVALID & arready_q;
  wire [7:0] ra = {S_AXI_ARADDR[7:2], 2'b00};
  wire fetch_rd = ar_take && ra == mscc_pkg::OFS_FETCH;
  wire mark_rd = fetch_rd && BUF_EMPTY; // [RQ17]
  wire mark_last = mark_dflt_q || ({1'b0, mark_ptr_q} == mark_len_q - 1'b1);
  wire [7:0] mark_chr = mark_dflt_q ? mscc_pkg::MARK_DFLT : mark_mem[mark_ptr_q]; // [RQ18]
  wire [7:0] st1_w = {3'b000, err_q, 2'b00, seq_q != mscc_pkg::S_IDLE, homed_q};
  // Trigger source shows in bits 7..5 except while adjusting
  wire [7:0] st3_w = {adj_any ? 3'b000 : trs_q, trs_sync_q, 4'(adj_q)}; // [RQ5]
  wire [7:0] mot_w = {2'b00, seq_def_q, auto_q, home_q != mscc_pkg::H_IDLE, seq_dir_q,
                      bwd_q, fwd_q};
  wire rd_map = ra == mscc_pkg::OFS_CMD || ra == mscc_pkg::OFS_STAT1
                || ra == mscc_pkg::OFS_STAT3 || ra == mscc_pkg::OFS_MOTOR
                || ra == mscc_pkg::OFS_FETCH || ra == mscc_pkg::OFS_MARKLEN;
  wire [31:0] rd_w = (ra == mscc_pkg::OFS_STAT1) ? {24'h00_0000, st1_w} :
                     (ra == mscc_pkg::OFS_STAT3) ? {24'h00_0000, st3_w} :
                     (ra == mscc_pkg::OFS_MOTOR) ? {24'h00_0000, mot_w} :
                     (ra == mscc_pkg::OFS_MARKLEN) ? 32'(mark_len_q) :
                     (ra == mscc_pkg::OFS_FETCH) ?
                       (BUF_EMPTY ? {22'h00_0000, 1'b1, mark_last, mark_chr} : RESULT_DATA) :
                     32'h0000_0000;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= mscc_pkg::RESP_OKAY;
      pop_q <= 1'b0;
      mark_len_q <= (PW + 1)'(1);
      mark_ptr_q <= '0;
      mark_dflt_q <= 1'b1;
    end
    else
    begin
      pop_q <= fetch_rd && !BUF_EMPTY;
      if (ar_take)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_w;
        rresp_q <= rd_map ? mscc_pkg::RESP_OKAY : mscc_pkg::RESP_SLVERR;
      end
      else if (rvalid_q && S_AXI_RREADY)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
      // Marker read pointer walks the string and wraps after the last character
      if (cmd_go && (op == mscc_pkg::OP_EOD_DFLT || op == mscc_pkg::OP_EOD_NEW))
      begin
        mark_dflt_q <= op == mscc_pkg::OP_EOD_DFLT; // [RQ18]
        mark_len_q <= (PW + 1)'(1);
        mark_ptr_q <= '0;
      end
      else if (c_eod_add)
        mark_len_q <= mark_len_q + 1'b1; // [RQ16]
      else if (mark_rd)
        mark_ptr_q <= mark_last ? '0 : mark_ptr_q + 1'b1; // [RQ17]
    end
  end

  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign MOTOR_FWD = fwd_q;
  assign MOTOR_BWD = bwd_q;
  assign FORWARD_IND = fwd_q; // [RQ19]
  assign BACKWARD_IND = bwd_q; // [RQ19]
  assign CNT_CLR = cnt_clr_q;
  assign SEQ_START = seq_start_q;
  assign SEQ_ABORT = seq_abort_q;
  assign TRIG_SRC = trs_q;
  assign TRIG_SYNC = trs_sync_q;
  assign ADJ_ACTIVE = adj_q;
  assign ADJ_TRIG = adj_trig_q;
  assign RESULT_POP = pop_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  chk_adj_on_set: assert property (c_adj_on |=> (ADJ_ACTIVE & $past(arg[NCHAN-1:0])) == $past(arg[NCHAN-1:0])) // [RQ1]
    else $error("offset adjust not entered");
  chk_adj_off_clr: assert property (c_adj_off && !btn_evt |=> (ADJ_ACTIVE & $past(off_mask)) == '0) // [RQ2]
    else $error("offset adjust not left");
  chk_adj_trig_gap: assert property (ADJ_TRIG |-> adj_cnt_q == '0 ##1 !ADJ_TRIG) // [RQ3]
    else $error("adjust triggers too close");
  chk_stat3_zero: assert property (adj_any |-> st3_w[7:5] == 3'b000) // [RQ5]
    else $error("status three bits not zero in adjust");
  chk_home_order: assert property (CNT_CLR && !homed_q && !c_abort && !c_trs && !c_mot_stop |=> !MOTOR_FWD && !MOTOR_BWD && !homed_q ##1 homed_q) // [RQ7]
    else $error("homing end order wrong");
  chk_home_nodir: assert property (c_home && arg == mscc_pkg::ARG_NONE && !fwd_q && !bwd_q |=> !MOTOR_FWD && !MOTOR_BWD) // [RQ8]
    else $error("motor moved on homing without direction");
  chk_motor_plus: assert property (c_mot_fwd |=> MOTOR_FWD && !MOTOR_BWD) // [RQ9]
    else $error("motor plus did not run forward");
  chk_stop_auto: assert property (c_mot_stop |=> !auto_q && !MOTOR_FWD && !MOTOR_BWD) // [RQ10]
    else $error("motor stop incomplete");
  chk_run_busy: assert property (run_bad |=> err_q && $stable(seq_q) || c_abort) // [RQ14]
    else $error("busy run not flagged");
  chk_abort_all: assert property (c_abort |=> SEQ_ABORT && seq_q == mscc_pkg::S_IDLE && !MOTOR_FWD && !MOTOR_BWD) // [RQ15]
    else $error("abort incomplete");
  chk_trs_cancel: assert property (c_trs |=> !auto_q && !seq_def_q && !MOTOR_FWD) // [RQ20]
    else $error("source select did not cancel");
  chk_ind_follow: assert property (FORWARD_IND == MOTOR_FWD && BACKWARD_IND == MOTOR_BWD) // [RQ19]
    else $error("indicator mismatch");

  cov_homing: cover property (home_q == mscc_pkg::H_SEEK ##[1:1000] homed_q);
  cov_sync_run: cover property (seq_q == mscc_pkg::S_WAIT ##[1:1000] SEQ_START);
  cov_marker: cover property (mark_rd && !mark_dflt_q && mark_last);
endmodule
